// >>> iev_ctrl.v
// Purpose: interrupt acceptance, two-level nesting and vectoring
// Assumes: request inputs are levels synchronous to core_clk
// Notes:   CPU pulses irq_take to accept and reti_done on return
//
// Function
// - No source is accepted unless the global gate bit 7 is 1.
// - A source needs both the global gate and its own enable set.
// - Enable bit 0 blocks its source; 1 allows it.
// - Accepted source branches to 0x0003 plus 8 times its order index.
// - Timer 2 overflow or capture share one request and one vector.
// - Third enable register bit gates the conversion done request.
// - Second enable register bit 4 gates external interrupt 6.
// - Third enable register bit 1 gates Timer 4 overflow.
// - Enable registers accept single-bit writes leaving other bits unchanged.
// - Active service blocks equal or lower levels; only higher level nests.
// - Same-level simultaneous requests resolve in fixed vector order.
// - Priority bit 1 means high level, 0 means low level.
`timescale 1ns/1ps
`include "iev_defs.vh"

module iev_ctrl #(
  parameter NSRC = `IEV_NSRC
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         resetn,
  // Register port
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  // Single-bit write port
  input  wire [7:0]   bit_addr,
  input  wire         bit_wdata,
  input  wire         bit_wr,
  // Peripheral request flags
  input  wire         ext0_request,
  input  wire         timer0_request,
  input  wire         ext1_request,
  input  wire         timer1_request,
  input  wire         rx_complete_flag,
  input  wire         tx_complete_flag,
  input  wire         timer2_overflow_flag,
  input  wire         timer2_capture_flag,
  input  wire         watchdog_request,
  input  wire         ifcount_request,
  input  wire         conversion_done_request,
  input  wire         ext2_request,
  input  wire         ext3_request,
  input  wire         ext4_request,
  input  wire         serial1_request,
  input  wire         serial2_request,
  input  wire         ext5_request,
  input  wire         ext6_request,
  input  wire         timer3_request,
  input  wire         timer4_request,
  // CPU side
  input  wire [15:0]  return_pc,
  input  wire         irq_take,
  input  wire         reti_done,
  output reg          irq_pending,
  output reg  [15:0]  irq_vector,
  output reg          irq_level,
  output reg          stack_push,
  output reg  [15:0]  stack_pc,
  output reg  [1:0]   in_service
);

  // Enable and priority registers
  reg  [7:0] en0;
  reg  [7:0] en1;
  reg  [7:0] en2;
  reg  [7:0] pri0;
  reg  [7:0] pri1;
  reg  [7:0] pri2;

  wire global_irq_gate;
  wire timer2_irq_en;
  wire serial0_irq_en;
  wire ext6_irq_en;
  wire conversion_done_irq_en;
  wire timer4_irq_en;
  wire serial0_request;
  wire timer2_request;

  wire [NSRC-1:0] src_req;
  wire [NSRC-1:0] src_en;
  wire [NSRC-1:0] src_hi;
  wire [NSRC-1:0] live;
  wire [NSRC-1:0] live_hi;
  wire [NSRC-1:0] live_lo;
  wire            hi_ok;
  wire            lo_ok;
  wire [4:0]      pick_hi;
  wire [4:0]      pick_lo;

  reg  [4:0]      next_idx;
  reg             next_level;
  reg             next_pending;

  // First set bit in order, or none
  function [4:0] first_set;
    input [NSRC-1:0] v;
    integer k;
    begin
      first_set = `IEV_NONE_IDX;
      for (k = NSRC - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[4:0];
        end
      end
    end
  endfunction

  // Fixed vector of an order index
  function [15:0] vec_of;
    input [4:0] idx;
    begin
      vec_of = `IEV_VEC_BASE + {8'h00, idx, 3'b000};
    end
  endfunction

  // Masked merge for byte and bit writes
  function [7:0] merge;
    input [7:0] old;
    input [7:0] sel;
    input [7:0] val;
    input [7:0] wmask;
    begin
      merge = ((old & ~sel) | (val & sel)) & wmask;
    end
  endfunction

  // Byte-wide or single-bit write steering
  function [7:0] upd;
    input [7:0] old;
    input [7:0] off;
    input [7:0] wmask;
    begin
      upd = old;
      if (reg_wr && reg_addr == off) begin
        upd = merge(old, 8'hff, reg_wdata, wmask);
      end else if (bit_wr && {bit_addr[7:3], 3'b000} == off) begin
        upd = merge(old, 8'h01 << bit_addr[2:0],
                    {8{bit_wdata}}, wmask);
      end
    end
  endfunction

  assign global_irq_gate        = en0[`IEV_GLOBAL_BIT];
  assign timer2_irq_en          = en0[`IEV_T2_BIT];
  assign serial0_irq_en         = en0[`IEV_S0_BIT];
  assign ext6_irq_en            = en1[`IEV_EX6_BIT];
  assign conversion_done_irq_en = en2[`IEV_ADC_BIT];
  assign timer4_irq_en          = en2[`IEV_T4_BIT];

  // Shared requests of serial 0 and Timer 2
  assign serial0_request = rx_complete_flag | tx_complete_flag;
  assign timer2_request  = timer2_overflow_flag | timer2_capture_flag;

  assign src_req = {timer4_request, timer3_request,
                    ext6_request, ext5_request,
                    serial2_request, serial1_request,
                    ext4_request, ext3_request, ext2_request,
                    conversion_done_request, ifcount_request,
                    watchdog_request, timer2_request,
                    serial0_request, timer1_request,
                    ext1_request, timer0_request, ext0_request};

  // Per-source enables in order
  assign src_en = {timer4_irq_en, en2[0],
                   ext6_irq_en, en1[3],
                   en2[3], en2[2],
                   en1[2], en1[1], en1[0],
                   conversion_done_irq_en,
                   en2[`IEV_IFC_BIT],
                   en2[`IEV_WDT_BIT], timer2_irq_en,
                   serial0_irq_en, en0[3:0]};

  // Priority levels, same layout as enables
  assign src_hi = {pri2[1], pri2[0], pri1[4], pri1[3],
                   pri2[3], pri2[2], pri1[2], pri1[1], pri1[0],
                   pri2[5], pri2[4], pri2[6], pri0[5:0]};

  // Gate: global and own enable both needed
  assign live    = src_req & src_en & {NSRC{global_irq_gate}};
  assign live_hi = live & src_hi;
  assign live_lo = live & ~src_hi;

  // Nesting: high waits only on high; low waits on either
  assign hi_ok = ~in_service[1];
  assign lo_ok = ~in_service[1] & ~in_service[0];

  assign pick_hi = first_set(live_hi);
  assign pick_lo = first_set(live_lo);

  // Request selection
  always @* begin
    next_idx     = `IEV_NONE_IDX;
    next_level   = 1'b0;
    next_pending = 1'b0;
    if (hi_ok && |live_hi) begin
      next_idx     = pick_hi;
      next_level   = 1'b1;
      next_pending = 1'b1;
    end else if (lo_ok && |live_lo) begin
      next_idx     = pick_lo;
      next_pending = 1'b1;
    end
  end

  // Register writes
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en0  <= `IEV_RST_VAL;
      en1  <= `IEV_RST_VAL;
      en2  <= `IEV_RST_VAL;
      pri0 <= `IEV_RST_VAL;
      pri1 <= `IEV_RST_VAL;
      pri2 <= `IEV_RST_VAL;
    end else begin
      en0  <= upd(en0,  `IEV_EN0_OFF,  `IEV_EN0_MASK);
      en1  <= upd(en1,  `IEV_EN1_OFF,  `IEV_EN1_MASK);
      en2  <= upd(en2,  `IEV_EN2_OFF,  `IEV_EN2_MASK);
      pri0 <= upd(pri0, `IEV_PRI0_OFF, `IEV_PRI0_MASK);
      pri1 <= upd(pri1, `IEV_PRI1_OFF, `IEV_EN1_MASK);
      pri2 <= upd(pri2, `IEV_PRI2_OFF, `IEV_EN2_MASK);
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IEV_EN0_OFF:  reg_rdata <= en0;
        `IEV_EN1_OFF:  reg_rdata <= en1;
        `IEV_EN2_OFF:  reg_rdata <= en2;
        `IEV_PRI0_OFF: reg_rdata <= pri0;
        `IEV_PRI1_OFF: reg_rdata <= pri1;
        `IEV_PRI2_OFF: reg_rdata <= pri2;
        `IEV_STAT_OFF: reg_rdata <= {irq_pending, irq_level,
                                     in_service, 4'h0};
        default:       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Request to the CPU; dropped the cycle after a take
  // so a stale vector is never offered twice
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_pending <= 1'b0;
      irq_vector  <= 16'h0000;
      irq_level   <= 1'b0;
    end else if (irq_take && irq_pending) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= next_pending;
      irq_level   <= next_level;
      if (next_pending) begin
        irq_vector <= vec_of(next_idx);
      end
    end
  end

  // In-service levels and stack push
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_service <= 2'b00;
      stack_push <= 1'b0;
      stack_pc   <= 16'h0000;
    end else begin
      stack_push <= 1'b0;
      if (irq_take && irq_pending) begin
        stack_push <= 1'b1;
        stack_pc   <= return_pc;
        if (irq_level) begin
          in_service[1] <= 1'b1;
        end else begin
          in_service[0] <= 1'b1;
        end
      end else if (reti_done) begin
        // Return closes the innermost level first
        if (in_service[1]) begin
          in_service[1] <= 1'b0;
        end else begin
          in_service[0] <= 1'b0;
        end
      end
    end
  end

endmodule

// >>> iev_defs.vh
// Purpose: constants of the interrupt enable and vectoring block
// Assumes: 8-bit register port, one core clock
// Notes:   definitions only
`ifndef IEV_DEFS_VH
`define IEV_DEFS_VH

// Register offsets
`define IEV_EN0_OFF      8'ha8
`define IEV_EN1_OFF      8'hb0
`define IEV_EN2_OFF      8'hc0
`define IEV_PRI0_OFF     8'hb8
`define IEV_PRI1_OFF     8'hb1
`define IEV_PRI2_OFF     8'hc1
`define IEV_STAT_OFF     8'hc9

// Writable bits; the rest read zero
`define IEV_EN0_MASK     8'hbf
`define IEV_EN1_MASK     8'h1f
`define IEV_EN2_MASK     8'h7f
`define IEV_PRI0_MASK    8'h3f
`define IEV_RST_VAL      8'h00

// Field positions
`define IEV_GLOBAL_BIT   7
`define IEV_T2_BIT       5
`define IEV_S0_BIT       4
`define IEV_EX6_BIT      4
`define IEV_WDT_BIT      6
`define IEV_ADC_BIT      5
`define IEV_IFC_BIT      4
`define IEV_T4_BIT       1

// Vector table
`define IEV_VEC_BASE     16'h0003
`define IEV_VEC_STEP     16'h0008
`define IEV_NSRC         18
`define IEV_IDX_W        5
`define IEV_NONE_IDX     5'h1f

// Source order, highest first
`define IEV_SRC_EX0      0
`define IEV_SRC_T0       1
`define IEV_SRC_EX1      2
`define IEV_SRC_T1       3
`define IEV_SRC_S0       4
`define IEV_SRC_T2       5
`define IEV_SRC_WDT      6
`define IEV_SRC_IFC      7
`define IEV_SRC_ADC      8
`define IEV_SRC_EX2      9
`define IEV_SRC_EX3      10
`define IEV_SRC_EX4      11
`define IEV_SRC_S1       12
`define IEV_SRC_S2       13
`define IEV_SRC_EX5      14
`define IEV_SRC_EX6      15
`define IEV_SRC_T3       16
`define IEV_SRC_T4       17

`endif

// >>> iev_ctrl_chk.sv
// Purpose: port assertions of the interrupt block
// Assumes: one clock, async active-low reset
// Notes:   bound to iev_ctrl below
`timescale 1ns/1ps
module iev_chk #(
  parameter NSRC = 18
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // CPU side
  input wire logic [15:0] return_pc,
  input wire logic        irq_take,
  input wire logic        reti_done,
  input wire logic        irq_pending,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_level,
  input wire logic        stack_push,
  input wire logic [15:0] stack_pc,
  input wire logic [1:0]  in_service
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire took = irq_take && irq_pending;

  property p_push; took |=> stack_push && stack_pc == $past(return_pc); endproperty
  a_push: assert property (p_push) else $error("no push");
  property p_drop; took |=> !irq_pending; endproperty
  a_drop: assert property (p_drop) else $error("still pending");
  property p_ins; took |=> in_service == ($past(in_service) | ($past(irq_level) ? 2'h2 : 2'h1)); endproperty
  a_ins: assert property (p_ins) else $error("bad level mark");
  property p_reti; reti_done && !took && in_service[1] |=> in_service == {1'b0, $past(in_service[0])}; endproperty
  a_reti: assert property (p_reti) else $error("bad return");
  property p_pulse; stack_push |=> !stack_push; endproperty
  a_pulse: assert property (p_pulse) else $error("long push");
  property p_vec; irq_pending |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h008b; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_low; irq_pending && in_service != 2'h0 |-> irq_level; endproperty
  a_low: assert property (p_low) else $error("low nested");
  property p_high; in_service[1] |-> !irq_pending; endproperty
  a_high: assert property (p_high) else $error("high nested");
  property p_unmap; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule

bind iev_ctrl iev_chk #(.NSRC(NSRC)) u_chk (.core_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .return_pc,
  .irq_take, .reti_done, .irq_pending, .irq_vector, .irq_level, .stack_push, .stack_pc, .in_service);

// >>> iev_cpu.sv
// Purpose: CPU model that takes offered vectors and returns
// Assumes: bench pulses take_req and ret_req
// Notes:   return PC steps by one per take
`timescale 1ns/1ps
module iev_cpu (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Block side
  input  wire logic        irq_pending,
  output logic             irq_take,
  output logic             reti_done,
  output logic [15:0]      return_pc,
  // Bench side
  input  wire logic        take_req,
  input  wire logic        ret_req
);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_take  <= 1'b0;
      reti_done <= 1'b0;
      return_pc <= 16'h0100;
    end else begin
      // One-cycle take, only while offered
      irq_take  <= take_req && irq_pending && !irq_take;
      reti_done <= ret_req;
      if (irq_take) begin
        return_pc <= return_pc + 16'h0001;
      end
    end
  end
endmodule

// >>> interrupt_enable_vectoring_tb.sv
// Purpose: directed bench of the interrupt block
// Assumes: CPU model answers takes and returns
// Notes:   requests driven as one vector rq
`timescale 1ns/1ps
module interrupt_enable_vectoring_tb;
  logic        core_clk, resetn, reg_wr, reg_rd, bit_wr, bit_wdata, alt, take_req, ret_req;
  logic        irq_take, reti_done, irq_pending, irq_level, stack_push;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, bit_addr;
  logic [17:0] rq;
  logic [15:0] return_pc, irq_vector, stack_pc;
  logic [1:0]  in_service;
  int          n_errors, compares;

  iev_ctrl dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_addr, .bit_wdata,
    .bit_wr, .ext0_request(rq[0]), .timer0_request(rq[1]), .ext1_request(rq[2]), .timer1_request(rq[3]),
    .rx_complete_flag(rq[4] & ~alt), .tx_complete_flag(rq[4] & alt), .timer2_overflow_flag(rq[5] & ~alt),
    .timer2_capture_flag(rq[5] & alt), .watchdog_request(rq[6]), .ifcount_request(rq[7]),
    .conversion_done_request(rq[8]), .ext2_request(rq[9]), .ext3_request(rq[10]), .ext4_request(rq[11]),
    .serial1_request(rq[12]), .serial2_request(rq[13]), .ext5_request(rq[14]), .ext6_request(rq[15]),
    .timer3_request(rq[16]), .timer4_request(rq[17]), .return_pc, .irq_take, .reti_done, .irq_pending,
    .irq_vector, .irq_level, .stack_push, .stack_pc, .in_service);
  iev_cpu cpu (.core_clk, .resetn, .irq_pending, .irq_take, .reti_done, .return_pc, .take_req, .ret_req);

  task final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task bset(input [7:0] a, input d);
    @(posedge core_clk);
    bit_addr  <= a;
    bit_wdata <= d;
    bit_wr    <= 1'b1;
    @(posedge core_clk);
    bit_wr    <= 1'b0;
  endtask
  // Bounded, so a dead block cannot hang the run
  task wait_p(input e);
    int k;
    k = 0;
    while (irq_pending !== e && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    if (irq_pending !== e) begin
      n_errors++;
      $display("[ERR] %0t pending timeout", $time);
      final_report;
    end
  endtask
  task idle(input e);
    repeat (4) @(negedge core_clk);
    chk(irq_pending, e);
  endtask
  task take(input [15:0] pc, input [1:0] ins);
    @(posedge core_clk);
    take_req <= 1'b1;
    @(posedge core_clk);
    take_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(stack_push, 1'b1);
    chk(stack_pc, pc);
    chk(in_service, ins);
  endtask
  task ret(input [1:0] ins);
    @(posedge core_clk);
    ret_req <= 1'b1;
    @(posedge core_clk);
    ret_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(in_service, ins);
  endtask

  task t_regs;
    rd(8'ha8, 8'h00);
    // Reserved bits are only ever written as zero
    wr(8'ha8, 8'hbf);
    rd(8'ha8, 8'hbf);
    wr(8'hb0, 8'h1f);
    rd(8'hb0, 8'h1f);
    wr(8'hc0, 8'h7f);
    rd(8'hc0, 8'h7f);
    wr(8'hb8, 8'h3f);
    rd(8'hb8, 8'h3f);
    wr(8'hb1, 8'h1f);
    rd(8'hb1, 8'h1f);
    wr(8'hc1, 8'h7f);
    rd(8'hc1, 8'h7f);
    // Levels back to low so later scenarios see one level
    wr(8'hb8, 8'h00);
    wr(8'hb1, 8'h00);
    wr(8'hc1, 8'h00);
    rd(8'hc1, 8'h00);
    rd(8'hc9, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'ha8, 8'h01);
    bset(8'haf, 1'b1);
    rd(8'ha8, 8'h81);
    bset(8'ha8, 1'b0);
    rd(8'ha8, 8'h80);
  endtask
  task t_gate;
    wr(8'ha8, 8'h3f);
    @(posedge core_clk);
    rq <= 18'h00001;
    idle(1'b0);
    bset(8'haf, 1'b1);
    wait_p(1'b1);
    chk(irq_vector, 16'h0003);
    rd(8'hc9, 8'h80);
    bset(8'ha8, 1'b0);
    wait_p(1'b0);
  endtask
  task t_vec;
    int i, s;
    wr(8'ha8, 8'hbf);
    wr(8'hb0, 8'h1f);
    wr(8'hc0, 8'h7f);
    for (i = 0; i < 20; i++) begin
      s = (i < 18) ? i : i - 14;
      @(posedge core_clk);
      rq  <= 18'h00001 << s;
      alt <= (i > 17);
      wait_p(1'b1);
      chk(irq_vector, 16'h0003 + 16'h0008 * 16'(s));
      @(posedge core_clk);
      rq <= 18'h00000;
      wait_p(1'b0);
    end
    @(posedge core_clk);
    rq <= 18'h28100;
    wait_p(1'b1);
    chk(irq_vector, 16'h0043);
    bset(8'hc5, 1'b0);
    idle(1'b1);
    chk(irq_vector, 16'h007b);
    bset(8'hb4, 1'b0);
    idle(1'b1);
    chk(irq_vector, 16'h008b);
    bset(8'hc1, 1'b0);
    idle(1'b0);
  endtask
  task t_nest;
    bset(8'hc1, 1'b1);
    @(posedge core_clk);
    rq <= 18'h20001;
    wait_p(1'b1);
    chk(irq_level, 1'b0);
    take(16'h0100, 2'h1);
    idle(1'b0);
    wr(8'hc1, 8'h02);
    wait_p(1'b1);
    chk(irq_vector, 16'h008b);
    chk(irq_level, 1'b1);
    rd(8'hc9, 8'hd0);
    take(16'h0101, 2'h3);
    rd(8'hc9, 8'h30);
    idle(1'b0);
    ret(2'h1);
    @(posedge core_clk);
    rq <= 18'h00000;
    ret(2'h0);
  endtask
  // Reset in mid-run drops the offer and the enables
  task t_rst;
    wr(8'ha8, 8'h81);
    @(posedge core_clk);
    rq <= 18'h00001;
    wait_p(1'b1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk(irq_pending, 1'b0);
    rd(8'ha8, 8'h00);
    idle(1'b0);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {resetn, reg_wr, reg_rd, bit_wr, bit_wdata, alt, take_req, ret_req} = 8'h00;
    {reg_addr, reg_wdata, bit_addr} = 24'h000000;
    rq = 18'h00000;
    n_errors = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_gate;
    t_vec;
    t_nest;
    t_rst;
    final_report;
  end
endmodule
